// [inc/bod_pkg.sv]
package bod_pkg;

  localparam int ADDR_W = 24;
  localparam logic [1:0] REG_RAM = 2'h0;
  localparam logic [1:0] REG_ROM = 2'h1;
  localparam logic [1:0] REG_SER = 2'h2;
  localparam logic [1:0] REG_FLP = 2'h3;
  // Overlay RAM window base; region one with A21 set
  localparam logic [23:0] OVL_RAM_BASE = 24'h60_0000;
  localparam logic [23:0] ROM_BASE = 24'h40_0000;
  localparam logic [23:0] ROM_CLR_LO = 24'h40_0000;
  localparam logic [23:0] ROM_CLR_HI = 24'h5F_FFFF;
  localparam logic [23:0] IO_LO = 24'h50_0000;
  localparam logic [23:0] IO_HI = 24'hFF_FFFF;
  localparam logic [23:0] VEC_HI = 24'h00_00FF;
  // Top RAM row offset for systems with more than 2MB
  localparam logic [23:0] TOP_ROW_OFS = 24'h20_0000;
  // Scheduler pattern: three processor slots per video slot
  localparam logic [1:0] CPU_PER_VID = 2'h3;
  localparam logic [1:0] VID_WORDS = 2'h2;
  localparam logic OVL_RESET = 1'b1;

  // Device select vector, exactly one hot while a cycle runs
  typedef struct packed {
    logic ram;
    logic rom;
    logic scsi;
    logic serial_comm_controller;
    logic floppy_disk_controller;
    logic iface_adapter;
  } bod_sel_t;

  // Processor request
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
  } bod_req_t;

  // RAM arbiter owner
  typedef enum logic [1:0] {
    OWN_CPU = 2'b00,
    OWN_VID = 2'b01,
    OWN_SND = 2'b10
  } bod_own_t;

endpackage : bod_pkg

// [tb/bod_cpu_model.sv]
`timescale 1ns/10ps
// Processor bus master: holds an access until ready
module bod_cpu_model
  import bod_pkg::*;
(
  // Control
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [23:0] addr,
  input wire logic cpu_ready,
  input bod_pkg::bod_sel_t dev_sel,
  // Bus side
  output bod_pkg::bod_req_t req,
  output bod_pkg::bod_sel_t got,
  output logic done
);
  initial begin
    req = '0;
    done = 1'b0;
  end
  // Release with inverted address so stale values never match
  always @(posedge sys_clk) begin
    done <= 1'b0;
    if (req.valid && cpu_ready) begin
      req <= {1'b0, ~req.addr};
      got <= dev_sel;
      done <= 1'b1;
    end else if (go && !req.valid) begin
      req <= {1'b1, addr};
    end
  end
endmodule : bod_cpu_model

// [tb/bod_props.sv]
`timescale 1ns/10ps
// Port checks of the address decoder
module bod_props
  import bod_pkg::*;
(
  // Clock, reset and inputs
  input wire logic sys_clk,
  input wire logic rst,
  input bod_pkg::bod_req_t cpu_req,
  input wire logic ram_big,
  // Outputs
  input bod_pkg::bod_sel_t dev_sel,
  input wire logic [23:0] ram_addr,
  input wire logic cpu_ready,
  input wire logic overlay,
  input wire logic io_region,
  input bod_pkg::bod_own_t ram_owner,
  input wire logic vid_word_strobe,
  input wire logic snd_fetch
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Request shorthands
  wire v = cpu_req.valid;
  wire [23:0] a = cpu_req.addr;
  one_sel_a: assert property (v |-> $onehot(dev_sel))
    else $error("select not one-hot");
  ovl_clr_a: assert property (v && a[23:21] == 3'h2 |=> !overlay)
    else $error("overlay not cleared");
  ovl_hold_a: assert property (!overlay |=> !overlay)
    else $error("overlay came back");
  vec_rom_a: assert property (
    v && overlay && a[23:8] == 16'h0000 |-> dev_sel.rom)
    else $error("vector fetch not rom");
  top_row_a: assert property (
    v && dev_sel.ram && overlay && ram_big |=>
    ram_addr == {3'h1, $past(a[20:0])})
    else $error("top row address wrong");
  io_a: assert property (io_region == (v && a >= IO_LO))
    else $error("io region wrong");
  rom_full_a: assert property (v && dev_sel.rom |-> cpu_ready)
    else $error("rom stalled");
  vid_gap_a: assert property (
    $fell(vid_word_strobe) |-> !vid_word_strobe [*3])
    else $error("video slot too soon");
  vid_pair_a: assert property (
    $rose(vid_word_strobe) |=> vid_word_strobe ##1 !vid_word_strobe)
    else $error("video slot not two words");
  ram_free_a: assert property (
    v && dev_sel.ram && ram_owner == OWN_CPU |-> cpu_ready)
    else $error("idle ram stalled");
  ram_wait_a: assert property (
    v && dev_sel.ram && ram_owner != OWN_CPU |-> !cpu_ready)
    else $error("ram not held during slot");
  // Main scenarios
  cover property (vid_word_strobe);
  cover property (snd_fetch);
  cover property ($fell(overlay));
endmodule : bod_props
bind bod_decoder bod_props u_props (.sys_clk(sys_clk), .rst(rst),
  .cpu_req(cpu_req), .ram_big(ram_big), .dev_sel(dev_sel),
  .ram_addr(ram_addr), .cpu_ready(cpu_ready), .overlay(overlay),
  .io_region(io_region), .ram_owner(ram_owner),
  .vid_word_strobe(vid_word_strobe), .snd_fetch(snd_fetch));

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
  import bod_pkg::*;
  typedef struct packed {
    logic [23:0] a;
    bod_sel_t s;
    logic o;
    logic i;
  } bod_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ram_big = 1'b0;
  logic line_active = 1'b0;
  logic line_start = 1'b0;
  logic go = 1'b0;
  logic [23:0] addr = 24'h00_0000;
  bod_req_t cpu_req;
  bod_sel_t dev_sel, got;
  bod_own_t ram_owner;
  logic [23:0] ram_addr;
  logic cpu_ready, overlay, io_region, vws, snd, done;
  logic io_seen = 1'b0;
  int fails = 0;
  int num_checks = 0;
  int n;
  // Address, select, overlay afterwards, io region during access
  bod_row_t rows [9] = '{
    '{24'h00_00FC, 6'h10, 1'b1, 1'b0}, '{24'h60_0000, 6'h20, 1'b1, 1'b1},
    '{24'h5F_FFFE, 6'h10, 1'b0, 1'b1}, '{24'h00_0000, 6'h20, 1'b0, 1'b0},
    '{24'h3F_FFFE, 6'h20, 1'b0, 1'b0}, '{24'h60_0000, 6'h08, 1'b0, 1'b1},
    '{24'h9F_FFF0, 6'h04, 1'b0, 1'b1}, '{24'hC0_0000, 6'h02, 1'b0, 1'b1},
    '{24'hE0_0000, 6'h01, 1'b0, 1'b1}};
  bod_decoder DUT (.sys_clk(sys_clk), .rst(rst), .cpu_req(cpu_req),
    .ram_big(ram_big), .line_active(line_active), .line_start(line_start),
    .dev_sel(dev_sel), .ram_addr(ram_addr), .cpu_ready(cpu_ready),
    .overlay(overlay), .io_region(io_region), .ram_owner(ram_owner),
    .vid_word_strobe(vws), .snd_fetch(snd));
  bod_cpu_model u_cpu (.sys_clk(sys_clk), .go(go), .addr(addr),
    .cpu_ready(cpu_ready), .dev_sel(dev_sel), .req(cpu_req), .got(got),
    .done(done));
  always #25 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // One access; n counts cycles until done
  task automatic acc(input logic [23:0] a);
    addr = a;
    go = 1'b1;
    n = 0;
    @(posedge sys_clk);
    #5 go = 1'b0;
    // Request stands here, so the io flag is settled
    io_seen = io_region;
    while (done !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      #5 n++;
    end
    // A limit that runs out counts as a mismatch
    chk(32'(done), 32'h0000_0001);
  endtask : acc
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #5;
  endtask : tick
  task automatic end_of_test;
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // Watchdog
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
  // Main sequence
  initial begin
    tick(6);
    rst = 1'b0;
    chk(32'({overlay, ram_owner, ram_addr}),
        32'({1'b1, OWN_CPU, 24'h00_0000}));
    foreach (rows[i]) begin
      acc(rows[i].a);
      chk(32'(got), 32'(rows[i].s));
      chk(32'(overlay), 32'(rows[i].o));
      chk(32'(io_seen), 32'(rows[i].i));
    end
    acc(24'h00_0100);
    chk(n, 1);
    line_start = 1'b1;
    line_active = 1'b1;
    tick(1);
    line_start = 1'b0;
    n = 0;
    repeat (8) begin
      n += (snd === 1'b1);
      tick(1);
    end
    chk(n, 1);
    n = 0;
    while (vws !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    n = 0;
    repeat (50) begin
      n += (vws === 1'b1);
      tick(1);
    end
    chk(n, 20);
    repeat (5) begin
      acc(24'h40_0000);
      chk(n, 1);
      acc(24'h00_0200);
    end
    line_active = 1'b0;
    rst = 1'b1;
    ram_big = 1'b1;
    tick(2);
    rst = 1'b0;
    acc(24'h61_2344);
    chk(32'(got), 32'(6'h20));
    chk(32'(ram_addr), 32'(24'h21_2344));
    end_of_test();
  end
endmodule : tb

// [verilog/bod_decoder.sv]
`timescale 1ns/10ps
// Board address decoder with boot overlay and RAM scheduling
module bod_decoder
  import bod_pkg::*;
#(
  parameter int RAM_ROW_W = 21
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Processor request
  input bod_pkg::bod_req_t cpu_req,
  // Configuration strap: more than 2MB fitted
  input wire logic ram_big,
  // Scan timing
  input wire logic line_active,
  input wire logic line_start,
  // Selects and RAM address
  output bod_pkg::bod_sel_t dev_sel,
  output logic [23:0] ram_addr,
  output logic cpu_ready,
  output logic overlay,
  output logic io_region,
  // RAM slot status
  output bod_pkg::bod_own_t ram_owner,
  output logic vid_word_strobe,
  output logic snd_fetch
);
  import bod_pkg::*;

  logic ovl_reg, ovl_next;
  logic [23:0] ram_addr_reg, ram_addr_next;
  wire [23:0] a = cpu_req.addr;
  wire [1:0] region = a[23:22];
  wire in_rom_rgn = cpu_req.valid && (a >= ROM_CLR_LO) && (a <= ROM_CLR_HI);
  // Low half of ROM region is ROM, upper half SCSI; A21 splits them
  wire rom_hit_norm = (region == REG_ROM) && !a[21];
  wire scsi_hit = (region == REG_ROM) && a[21];
  wire rom_hit_ovl = ovl_reg && (region == REG_RAM);
  wire ovl_ram_hit = ovl_reg && (region == REG_ROM) && a[21];
  wire ram_norm = !ovl_reg && (region == REG_RAM);
  wire ram_hit = ram_norm || ovl_ram_hit;
  wire rom_hit = rom_hit_norm || rom_hit_ovl;
  wire sel_ok;
  wire sched_grant;

  // Overlay window: RAM at 600000 when active; it shadows SCSI slot there
  assign io_region = cpu_req.valid &&
                     (a >= IO_LO) && (a <= IO_HI);

  // One-hot select; overlay RAM window takes priority over SCSI
  always_comb begin
    dev_sel = '0;
    if (cpu_req.valid) begin
      if (rom_hit) dev_sel.rom = 1'b1;
      else if (ram_hit) dev_sel.ram = 1'b1;
      else if (scsi_hit) dev_sel.scsi = 1'b1;
      else if (region == REG_SER) dev_sel.serial_comm_controller = 1'b1;
      else if (a[21]) dev_sel.iface_adapter = 1'b1;
      else dev_sel.floppy_disk_controller = 1'b1;
    end
  end
  assign sel_ok = dev_sel.ram || dev_sel.rom || dev_sel.scsi ||
                  dev_sel.serial_comm_controller ||
                  dev_sel.floppy_disk_controller || dev_sel.iface_adapter;

  // RAM address: overlay window maps to the top row when memory is large
  always_comb begin
    ram_addr_next = ram_addr_reg;
    if (dev_sel.ram) begin
      if (ovl_ram_hit && ram_big)
        ram_addr_next = TOP_ROW_OFS | (a & ((24'h00_0001 << RAM_ROW_W)
                        - 24'h00_0001));
      else if (ovl_ram_hit)
        ram_addr_next = a - OVL_RAM_BASE;
      else
        ram_addr_next = a;
    end
  end

  // Overlay clears on first access into ROM span 400000-5FFFFF; SCSI span leaves it set
  assign ovl_next = in_rom_rgn ? 1'b0 : ovl_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ovl_reg <= OVL_RESET;
      ram_addr_reg <= 24'h00_0000;
    end else begin
      ovl_reg <= ovl_next;
      ram_addr_reg <= ram_addr_next;
    end
  end

  // Slot scheduler for shared RAM
  bod_ram_sched u_sched (
    .sys_clk(sys_clk),
    .rst(rst),
    .line_active(line_active),
    .line_start(line_start),
    .cpu_ram_req(dev_sel.ram),
    .cpu_grant(sched_grant),
    .owner(ram_owner),
    .vid_word_strobe(vid_word_strobe),
    .snd_fetch(snd_fetch)
  );

  // ROM and I/O never wait for video; RAM waits on its slot
  assign cpu_ready = sel_ok && (!dev_sel.ram || sched_grant);
  assign overlay = ovl_reg;
  assign ram_addr = ram_addr_reg;

endmodule : bod_decoder

// [verilog/bod_ram_sched.sv]
`timescale 1ns/10ps
// RAM slot scheduler between processor, video and sound/disk-speed fetch
module bod_ram_sched
  import bod_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Scan timing from video logic
  input wire logic line_active,
  input wire logic line_start,
  // Processor RAM demand
  input wire logic cpu_ram_req,
  // Grants
  output logic cpu_grant,
  output bod_pkg::bod_own_t owner,
  output logic vid_word_strobe,
  output logic snd_fetch
);
  import bod_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SND = 2'b01,
    ST_VID = 2'b10
  } bod_sst_t;

  bod_sst_t state_reg, state_next;
  logic [1:0] cpu_cnt_reg, cpu_cnt_next;
  logic [1:0] word_reg, word_next;
  logic snd_pend_reg, snd_pend_next;

  // Slot sequencing
  always_comb begin
    state_next = state_reg;
    cpu_cnt_next = cpu_cnt_reg;
    word_next = word_reg;
    snd_pend_next = snd_pend_reg | line_start;
    case (state_reg)
      ST_IDLE: begin
        if (snd_pend_reg) begin
          state_next = ST_SND;
          snd_pend_next = line_start;
        // Idle cycles counted 0..2 give three processor slots per video slot
        end else if (line_active && cpu_cnt_reg == CPU_PER_VID - 2'h1) begin
          state_next = ST_VID;
          word_next = 2'h0;
        end else if (line_active) begin
          cpu_cnt_next = cpu_cnt_reg + 2'h1;
        end
      end
      ST_SND: state_next = ST_IDLE;
      ST_VID: begin
        word_next = word_reg + 2'h1;
        if (word_reg == VID_WORDS - 2'h1) begin
          state_next = ST_IDLE;
          cpu_cnt_next = 2'h0;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cpu_cnt_reg <= 2'h0;
      word_reg <= 2'h0;
      snd_pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cpu_cnt_reg <= cpu_cnt_next;
      word_reg <= word_next;
      snd_pend_reg <= snd_pend_next;
    end
  end

  // Processor owns RAM whenever no other slot runs
  assign owner = (state_reg == ST_VID) ? OWN_VID :
                 (state_reg == ST_SND) ? OWN_SND : OWN_CPU;
  assign cpu_grant = cpu_ram_req && (state_reg == ST_IDLE);
  assign vid_word_strobe = (state_reg == ST_VID);
  assign snd_fetch = (state_reg == ST_SND);

endmodule : bod_ram_sched
